/* File: drive_param_pkg.sv */
/*
 * constants, types and the register map of the drive parameter bank.
 * assumes a 32-bit classic wishbone slave, word-indexed registers.
 */
package drive_param_pkg;
   // ==========================================================
   // sizes
   localparam int          NUM_PARAMS = 12;
   localparam int          DAT_W      = 32;
   localparam int          ADR_W      = 16;
   localparam int          VAL_W      = 16;
   localparam int          CNT_W      = 8;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [15:0] IDX_SOFT_START  = 16'h1326;
   localparam logic [15:0] IDX_DISP_RESTR  = 16'h1327;
   localparam logic [15:0] IDX_INIT_DISP   = 16'h1328;
   localparam logic [15:0] IDX_DECEL_MODE  = 16'h1334;
   localparam logic [15:0] IDX_VBUS_TRIG   = 16'h1335;
   localparam logic [15:0] IDX_OV_THRESH   = 16'h1336;
   localparam logic [15:0] IDX_DECEL_TIME  = 16'h1338;
   localparam logic [15:0] IDX_FREQ_DROP   = 16'h1339;
   localparam logic [15:0] IDX_CMP_UPPER   = 16'h133f;
   localparam logic [15:0] IDX_CMP_LOWER   = 16'h1340;
   localparam logic [15:0] IDX_CMP_HYST    = 16'h1341;
   localparam logic [15:0] IDX_LOSS_LEVEL  = 16'h1349;
   localparam logic [15:0] IDX_STATUS      = 16'h1380;

   // ==========================================================
   // storage slots
   localparam logic [3:0]  SL_SOFT_START = 4'h0;
   localparam logic [3:0]  SL_DISP_RESTR = 4'h1;
   localparam logic [3:0]  SL_INIT_DISP  = 4'h2;
   localparam logic [3:0]  SL_DECEL_MODE = 4'h3;
   localparam logic [3:0]  SL_VBUS_TRIG  = 4'h4;
   localparam logic [3:0]  SL_OV_THRESH  = 4'h5;
   localparam logic [3:0]  SL_DECEL_TIME = 4'h6;
   localparam logic [3:0]  SL_FREQ_DROP  = 4'h7;
   localparam logic [3:0]  SL_CMP_UPPER  = 4'h8;
   localparam logic [3:0]  SL_CMP_LOWER  = 4'h9;
   localparam logic [3:0]  SL_CMP_HYST   = 4'ha;
   localparam logic [3:0]  SL_LOSS_LEVEL = 4'hb;
   localparam logic [3:0]  SL_STATUS     = 4'hc;
   localparam logic [3:0]  SL_NONE       = 4'hf;

   // ==========================================================
   // value limits
   localparam logic [15:0] SOFT_START_MAX = 16'h00fa;
   localparam logic [15:0] DISP_FULL      = 16'h0000;
   localparam logic [15:0] DISP_FUNC      = 16'h0001;
   localparam logic [15:0] DISP_COMPARE   = 16'h0003;
   localparam logic [15:0] DISP_BASIC     = 16'h0004;
   localparam logic [15:0] DISP_MONITOR   = 16'h0005;
   localparam logic [15:0] INIT_DISP_MAX  = 16'h003c;
   localparam logic [15:0] INIT_DISP_A    = 16'h00c9;
   localparam logic [15:0] INIT_DISP_B    = 16'h00ca;
   localparam logic [15:0] DECEL_MODE_MAX = 16'h0003;
   localparam logic [15:0] VBUS_MAX_200   = 16'h0fa0;
   localparam logic [15:0] VBUS_MAX_400   = 16'h1f40;
   localparam logic [15:0] DECEL_TIME_MIN = 16'h0001;
   localparam logic [15:0] DECEL_TIME_MAX = 16'h7530;
   localparam logic [15:0] FREQ_DROP_MAX  = 16'h03e8;
   localparam logic [15:0] PCT_MAX        = 16'h0064;
   localparam logic [15:0] HYST_MAX       = 16'h000a;
   localparam logic [15:0] LOSS_NONE      = 16'h00ff;

   // ==========================================================
   // reset values, slot 0 in the low word
   localparam logic [NUM_PARAMS-1:0][15:0] PARAM_RESET = {
      16'h00ff, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0001,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // ==========================================================
   // status register fields
   localparam int          ST_REFUSED_BIT = 0;
   localparam int          ST_CLASS_BIT   = 1;
   localparam int          ST_COUNT_LSB   = 8;

   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_st_e;

   // field order mirrors slot order, highest slot first
   typedef struct packed {
      logic [15:0] input_loss_level;
      logic [15:0] comparator_hysteresis;
      logic [15:0] comparator_lower_limit;
      logic [15:0] comparator_upper_limit;
      logic [15:0] initial_freq_drop;
      logic [15:0] controlled_decel_time;
      logic [15:0] decel_overvoltage_threshold;
      logic [15:0] bus_voltage_trigger_level;
      logic [15:0] power_loss_decel_mode;
      logic [15:0] initial_display_select;
      logic [15:0] display_restriction;
      logic [15:0] soft_start_time;
   } params_s;
endpackage : drive_param_pkg

/* File: drive_param_bank.sv */
/*
 * drive parameter bank: range-checked 16-bit parameters behind a
 * classic wishbone slave, one word per register.
 * assumes one 125 MHz clock, synchronous active-high reset and a
 * voltage class strap that is steady around reset.
 */
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps

module drive_param_bank (
   // clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       rst_i,
   // voltage class strap, high for 400 V class
   input  wire logic                       volt_class_i,
   // wishbone slave
   input  wire logic                       cyc_i,
   input  wire logic                       stb_i,
   input  wire logic                       we_i,
   input  wire logic [3:0]                 sel_i,
   input  wire logic [15:0]                adr_i,
   input  wire logic [31:0]                dat_i,
   output logic      [31:0]                dat_o,
   output logic                            ack_o,
   output logic                            err_o,
   // stored parameters to the drive logic
   output drive_param_pkg::params_s        params_o
);

   // ==========================================================
   // decode of a word index to a storage slot
   function automatic logic [3:0] reg_slot(input logic [15:0] idx);
      case (idx)
         drive_param_pkg::IDX_SOFT_START: reg_slot = drive_param_pkg::SL_SOFT_START;
         drive_param_pkg::IDX_DISP_RESTR: reg_slot = drive_param_pkg::SL_DISP_RESTR;
         drive_param_pkg::IDX_INIT_DISP:  reg_slot = drive_param_pkg::SL_INIT_DISP;
         drive_param_pkg::IDX_DECEL_MODE: reg_slot = drive_param_pkg::SL_DECEL_MODE;
         drive_param_pkg::IDX_VBUS_TRIG:  reg_slot = drive_param_pkg::SL_VBUS_TRIG;
         drive_param_pkg::IDX_OV_THRESH:  reg_slot = drive_param_pkg::SL_OV_THRESH;
         drive_param_pkg::IDX_DECEL_TIME: reg_slot = drive_param_pkg::SL_DECEL_TIME;
         drive_param_pkg::IDX_FREQ_DROP:  reg_slot = drive_param_pkg::SL_FREQ_DROP;
         drive_param_pkg::IDX_CMP_UPPER:  reg_slot = drive_param_pkg::SL_CMP_UPPER;
         drive_param_pkg::IDX_CMP_LOWER:  reg_slot = drive_param_pkg::SL_CMP_LOWER;
         drive_param_pkg::IDX_CMP_HYST:   reg_slot = drive_param_pkg::SL_CMP_HYST;
         drive_param_pkg::IDX_LOSS_LEVEL: reg_slot = drive_param_pkg::SL_LOSS_LEVEL;
         drive_param_pkg::IDX_STATUS:     reg_slot = drive_param_pkg::SL_STATUS;
         default:                         reg_slot = drive_param_pkg::SL_NONE;
      endcase
   endfunction : reg_slot

   // ==========================================================
   // storage
   logic [drive_param_pkg::NUM_PARAMS-1:0][15:0] regs_ff;
   logic [drive_param_pkg::NUM_PARAMS-1:0][15:0] nxt_regs;
   drive_param_pkg::bus_st_e                     st_ff;
   drive_param_pkg::bus_st_e                     nxt_st;
   logic [31:0]                                  dat_ff;
   logic [31:0]                                  nxt_dat;
   logic                                         ack_ff;
   logic                                         nxt_ack;
   logic                                         err_ff;
   logic                                         nxt_err;
   logic                                         refused_ff;
   logic                                         nxt_refused;
   logic [drive_param_pkg::CNT_W-1:0]            rcnt_ff;
   logic [drive_param_pkg::CNT_W-1:0]            nxt_rcnt;
   logic                                         class400_ff;

   // the comparator pair is checked against the stored partners,
   // so software must widen the window before raising hysteresis
   logic [16:0] upper_v;
   logic [16:0] lower_v;
   logic [16:0] hyst2_v;
   logic [15:0] vbus_max;
   logic [15:0] wval;
   logic [15:0] req_idx;
   logic [3:0]  slot;
   logic        value_ok;
   logic        wr_ok;

   assign wval    = dat_i[15:0];
   assign req_idx = {2'b00, adr_i[15:2]};
   assign slot    = reg_slot(req_idx);

   // ==========================================================
   // value checks for the addressed slot
   always_comb begin
      upper_v  = {1'b0, regs_ff[drive_param_pkg::SL_CMP_UPPER]};
      lower_v  = {1'b0, regs_ff[drive_param_pkg::SL_CMP_LOWER]};
      hyst2_v  = {regs_ff[drive_param_pkg::SL_CMP_HYST], 1'b0};
      vbus_max = class400_ff ? drive_param_pkg::VBUS_MAX_400
                             : drive_param_pkg::VBUS_MAX_200;
      case (slot)
         drive_param_pkg::SL_SOFT_START: begin
            value_ok = (wval <= drive_param_pkg::SOFT_START_MAX);
         end
         drive_param_pkg::SL_DISP_RESTR: begin
            value_ok = (wval == drive_param_pkg::DISP_FULL)    ||
                       (wval == drive_param_pkg::DISP_FUNC)    ||
                       (wval == drive_param_pkg::DISP_COMPARE) ||
                       (wval == drive_param_pkg::DISP_BASIC)   ||
                       (wval == drive_param_pkg::DISP_MONITOR);
         end
         drive_param_pkg::SL_INIT_DISP: begin
            value_ok = (wval <= drive_param_pkg::INIT_DISP_MAX) ||
                       (wval == drive_param_pkg::INIT_DISP_A)   ||
                       (wval == drive_param_pkg::INIT_DISP_B);
         end
         drive_param_pkg::SL_DECEL_MODE: begin
            value_ok = (wval <= drive_param_pkg::DECEL_MODE_MAX);
         end
         drive_param_pkg::SL_VBUS_TRIG, drive_param_pkg::SL_OV_THRESH: begin
            value_ok = (wval <= vbus_max);
         end
         drive_param_pkg::SL_DECEL_TIME: begin
            value_ok = (wval >= drive_param_pkg::DECEL_TIME_MIN) &&
                       (wval <= drive_param_pkg::DECEL_TIME_MAX);
         end
         drive_param_pkg::SL_FREQ_DROP: begin
            value_ok = (wval <= drive_param_pkg::FREQ_DROP_MAX);
         end
         drive_param_pkg::SL_CMP_UPPER: begin
            value_ok = (wval <= drive_param_pkg::PCT_MAX) &&
                       ({1'b0, wval} >= lower_v + hyst2_v);
         end
         drive_param_pkg::SL_CMP_LOWER: begin
            value_ok = (wval <= drive_param_pkg::PCT_MAX) &&
                       ({1'b0, wval} + hyst2_v <= upper_v);
         end
         drive_param_pkg::SL_CMP_HYST: begin
            value_ok = (wval <= drive_param_pkg::HYST_MAX) &&
                       ({wval, 1'b0} + lower_v <= upper_v);
         end
         drive_param_pkg::SL_LOSS_LEVEL: begin
            value_ok = (wval <= drive_param_pkg::PCT_MAX) ||
                       (wval == drive_param_pkg::LOSS_NONE);
         end
         default: begin
            value_ok = 1'b0;
         end
      endcase
      // full 16-bit lanes, no high bits and an aligned address
      wr_ok = value_ok && (sel_i[1:0] == 2'b11) && (dat_i[31:16] == 16'h0000) &&
              (adr_i[1:0] == 2'b00);
   end

   // ==========================================================
   // bus answer and register update
   always_comb begin
      nxt_st      = drive_param_pkg::BUS_IDLE;
      nxt_regs    = regs_ff;
      nxt_dat     = dat_ff;
      nxt_ack     = 1'b0;
      nxt_err     = 1'b0;
      nxt_refused = refused_ff;
      nxt_rcnt    = rcnt_ff;
      case (st_ff)
         drive_param_pkg::BUS_IDLE: begin
            if (cyc_i && stb_i) begin
               nxt_st = drive_param_pkg::BUS_ANSWER;
               if (we_i) begin
                  if (wr_ok) begin
                     nxt_regs[slot] = wval;
                     nxt_ack        = 1'b1;
                     nxt_refused    = 1'b0;
                  end else begin
                     // stored value stays, error answer instead
                     nxt_err     = 1'b1;
                     nxt_refused = 1'b1;
                     if (rcnt_ff != {drive_param_pkg::CNT_W{1'b1}}) begin
                        nxt_rcnt = rcnt_ff + 8'h01;
                     end
                  end
               end else if (adr_i[1:0] != 2'b00 || slot == drive_param_pkg::SL_NONE) begin
                  nxt_err = 1'b1;
                  nxt_dat = 32'h0000_0000;
               end else if (slot == drive_param_pkg::SL_STATUS) begin
                  nxt_ack = 1'b1;
                  nxt_dat = 32'h0000_0000;
                  nxt_dat[drive_param_pkg::ST_REFUSED_BIT] = refused_ff;
                  nxt_dat[drive_param_pkg::ST_CLASS_BIT]   = class400_ff;
                  nxt_dat[drive_param_pkg::ST_COUNT_LSB +: drive_param_pkg::CNT_W] = rcnt_ff;
               end else begin
                  nxt_ack = 1'b1;
                  nxt_dat = {16'h0000, regs_ff[slot]};
               end
            end
         end
         drive_param_pkg::BUS_ANSWER: begin
            nxt_st = drive_param_pkg::BUS_IDLE;
         end
         default: begin
            nxt_st = drive_param_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_ff       <= drive_param_pkg::BUS_IDLE;
         regs_ff     <= drive_param_pkg::PARAM_RESET;
         dat_ff      <= 32'h0000_0000;
         ack_ff      <= 1'b0;
         err_ff      <= 1'b0;
         refused_ff  <= 1'b0;
         rcnt_ff     <= 8'h00;
         // strap is sampled by the clock while reset is held
         class400_ff <= volt_class_i;
      end else begin
         st_ff       <= nxt_st;
         regs_ff     <= nxt_regs;
         dat_ff      <= nxt_dat;
         ack_ff      <= nxt_ack;
         err_ff      <= nxt_err;
         refused_ff  <= nxt_refused;
         rcnt_ff     <= nxt_rcnt;
      end
   end

   assign dat_o    = dat_ff;
   assign ack_o    = ack_ff;
   assign err_o    = err_ff;
   assign params_o = drive_param_pkg::params_s'(regs_ff);

   // ==========================================================
   // checks
   AST_SOFT_START: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_SOFT_START] <= drive_param_pkg::SOFT_START_MAX)
      else $error("soft start time out of range");

   AST_DISP_RESTR: assert property (@(posedge mclk_i) disable iff (rst_i)
      (cyc_i && stb_i && we_i && st_ff == drive_param_pkg::BUS_IDLE &&
       slot == drive_param_pkg::SL_DISP_RESTR && wval == 16'h0002)
      |=> err_o && !ack_o)
      else $error("display restriction code 2 accepted");

   AST_INIT_DISP: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_INIT_DISP] <= drive_param_pkg::INIT_DISP_MAX ||
      regs_ff[drive_param_pkg::SL_INIT_DISP] == drive_param_pkg::INIT_DISP_A ||
      regs_ff[drive_param_pkg::SL_INIT_DISP] == drive_param_pkg::INIT_DISP_B)
      else $error("initial display selection out of set");

   AST_DECEL_MODE: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_DECEL_MODE] <= drive_param_pkg::DECEL_MODE_MAX)
      else $error("power loss mode above 3");

   // both levels share one class cap; the strap only moves under reset
   AST_VBUS: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_VBUS_TRIG] <= vbus_max &&
      regs_ff[drive_param_pkg::SL_OV_THRESH] <= vbus_max)
      else $error("bus voltage level above class limit");

   AST_DECEL_TIME: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_DECEL_TIME] >= drive_param_pkg::DECEL_TIME_MIN &&
      regs_ff[drive_param_pkg::SL_DECEL_TIME] <= drive_param_pkg::DECEL_TIME_MAX)
      else $error("decel time out of range");

   AST_FREQ_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_FREQ_DROP] <= drive_param_pkg::FREQ_DROP_MAX)
      else $error("frequency drop above 1000");

   AST_WINDOW: assert property (@(posedge mclk_i) disable iff (rst_i)
      {1'b0, regs_ff[drive_param_pkg::SL_CMP_UPPER]} >= lower_v + hyst2_v &&
      regs_ff[drive_param_pkg::SL_CMP_UPPER] <= drive_param_pkg::PCT_MAX)
      else $error("comparator window violated");

   AST_LOWER_REFUSE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (cyc_i && stb_i && we_i && st_ff == drive_param_pkg::BUS_IDLE &&
       slot == drive_param_pkg::SL_CMP_LOWER && {1'b0, wval} + hyst2_v > upper_v)
      |=> err_o ##1 !err_o)
      else $error("lower limit above window accepted");

   AST_HYST: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_CMP_HYST] <= drive_param_pkg::HYST_MAX)
      else $error("hysteresis above 10");

   AST_LOSS: assert property (@(posedge mclk_i) disable iff (rst_i)
      regs_ff[drive_param_pkg::SL_LOSS_LEVEL] <= drive_param_pkg::PCT_MAX ||
      regs_ff[drive_param_pkg::SL_LOSS_LEVEL] == drive_param_pkg::LOSS_NONE)
      else $error("loss level out of range");

   AST_REFUSED_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
      err_o |-> regs_ff == $past(regs_ff))
      else $error("refused access changed a register");

   // reserved indices answer with an error, never with data
   AST_RESERVED_ERR: assert property (@(posedge mclk_i) disable iff (rst_i)
      (cyc_i && stb_i && st_ff == drive_param_pkg::BUS_IDLE &&
       slot == drive_param_pkg::SL_NONE)
      |=> err_o && !ack_o)
      else $error("reserved address accepted");

endmodule : drive_param_bank

/* File: drive_param_host.sv */
/*
 * host model: classic wishbone master that reaches the parameter bank.
 * assumes the bank answers with ack or err within a few cycles.
 */
`timescale 1ns/100ps

module drive_param_host (
   // clock
   input  wire logic        mclk_i,
   // wishbone master
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [3:0]       sel_o,
   output logic [15:0]      adr_o,
   output logic [31:0]      dat_o,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   // wait limit used up
   output logic             hang_o
);
   initial begin
      cyc_o  = 1'b0;
      stb_o  = 1'b0;
      we_o   = 1'b0;
      sel_o  = 4'h0;
      adr_o  = 16'h0000;
      dat_o  = 32'h0000_0000;
      hang_o = 1'b0;
   end

   // =========================================================
   // single classic cycle, held until ack or err is sampled
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      @(posedge mclk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      sel_o <= s;
      adr_o <= a;
      dat_o <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack_i !== 1'b1 && err_i !== 1'b1 && n < 32);
      q  = dat_i;
      ok = (ack_i === 1'b1);
      if (ack_i !== 1'b1 && err_i !== 1'b1) begin
         hang_o <= 1'b1;
      end
      // released lines show the inverse so stale values cannot pass
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= ~w;
      sel_o <= ~s;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask : xfer
endmodule : drive_param_host

/* File: drive_param_bank_tb_top.sv */
/*
 * self-checking bench for the drive parameter bank.
 * assumes the host model as bus master and no other driver.
 */
`timescale 1ns/100ps

module drive_param_bank_tb_top;
   logic                      mclk_i;
   logic                      rst_i;
   logic                      volt_class_i;
   logic                      cyc, stb, we, ack, err, hang;
   logic [3:0]                sel;
   logic [15:0]               adr;
   logic [31:0]               dat_w, dat_r;
   drive_param_pkg::params_s  params;
   logic [191:0]              pv;
   int                        fails;
   int                        n_compared;
   int                        nrefw;
   logic [15:0]               shadow [16'h1326:16'h1349];
   localparam int             NR = 36;
   localparam logic [15:0] IDX_L [12] = '{16'h1326, 16'h1327, 16'h1328, 16'h1334,
      16'h1335, 16'h1336, 16'h1338, 16'h1339, 16'h133f, 16'h1340, 16'h1341, 16'h1349};
   localparam logic [15:0] RST_L [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h00ff};
   localparam logic [15:0] RSV_L [6] = '{16'h1329, 16'h1333, 16'h1337, 16'h133a,
      16'h1342, 16'h134a};
   // {accepted, index, value}; ranges first, then comparator cross limits
   localparam logic [32:0] TBL [47] = '{
      33'h0_1326_00fb, 33'h1_1326_0000, 33'h1_1326_00fa, 33'h1_1327_0005, 33'h1_1327_0004,
      33'h1_1327_0003, 33'h1_1327_0001, 33'h0_1327_0002, 33'h0_1327_0006, 33'h1_1327_0000,
      33'h1_1328_003c, 33'h0_1328_003d, 33'h1_1328_00c9, 33'h1_1328_00ca, 33'h0_1328_00c8,
      33'h0_1328_00cb, 33'h1_1328_0000, 33'h1_1334_0001, 33'h1_1334_0002, 33'h1_1334_0003,
      33'h0_1334_0004, 33'h1_1334_0000, 33'h1_1335_0fa0, 33'h0_1335_0fa1, 33'h1_1336_0fa0,
      33'h0_1336_0fa1, 33'h0_1338_0000, 33'h1_1338_7530, 33'h0_1338_7531, 33'h1_1338_0001,
      33'h1_1339_03e8, 33'h0_1339_03e9, 33'h1_1349_0064, 33'h0_1349_0065, 33'h0_1349_00fe,
      33'h1_1349_00ff,
      33'h0_1341_000b, 33'h1_1341_000a, 33'h0_1340_0051, 33'h1_1340_0050, 33'h0_133f_0063,
      33'h0_133f_0065, 33'h1_133f_0064, 33'h1_1341_0005, 33'h1_133f_005a, 33'h0_1341_0006,
      33'h1_1341_0000};

   assign pv = params;

   drive_param_bank i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .volt_class_i(volt_class_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat_w),
      .dat_o(dat_r), .ack_o(ack), .err_o(err), .params_o(params));
   drive_param_host i_host (.mclk_i(mclk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .sel_o(sel), .adr_o(adr), .dat_o(dat_w), .dat_i(dat_r), .ack_i(ack), .err_i(err),
      .hang_o(hang));

   // =========================================================
   // checking and bus helpers
   function automatic logic [15:0] ba(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction : ba

   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic wr_chk(input logic [15:0] idx, input logic [15:0] v, input logic okx);
      logic [31:0] q;
      logic        ok;
      i_host.xfer(1'b1, ba(idx), {16'h0000, v}, 4'hf, q, ok);
      cmp("write response", {63'd0, okx}, {63'd0, ok});
      if (okx) shadow[idx] = v;
      else nrefw++;
      i_host.xfer(1'b0, ba(idx), 32'h0000_0000, 4'hf, q, ok);
      cmp("read back", {31'd0, 1'b1, 16'h0000, shadow[idx]}, {31'd0, ok, q});
   endtask : wr_chk

   task automatic refw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      logic        ok;
      i_host.xfer(1'b1, a, d, s, q, ok);
      cmp("refused write", 64'd0, {63'd0, ok});
      nrefw++;
   endtask : refw

   task automatic chk_status(input logic cls, input logic last_bad);
      logic [31:0] q;
      logic        ok;
      i_host.xfer(1'b0, ba(drive_param_pkg::IDX_STATUS), 32'h0000_0000, 4'hf, q, ok);
      cmp("status", {31'd0, 1'b1, 16'h0000, nrefw[7:0], 6'h00, cls, last_bad},
          {31'd0, ok, q & 32'h0000_ff03});
   endtask : chk_status

   task automatic run_table(input int first, input int last);
      for (int i = first; i <= last; i++) begin
         wr_chk(TBL[i][31:16], TBL[i][15:0], TBL[i][32]);
      end
   endtask : run_table

   // =========================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] q;
      logic        ok;
      nrefw = 0;
      for (int k = 0; k < 12; k++) begin
         shadow[IDX_L[k]] = RST_L[k];
         cmp("reset output", {48'd0, RST_L[k]}, {48'd0, pv[16*k +: 16]});
         i_host.xfer(1'b0, ba(IDX_L[k]), 32'h0000_0000, 4'hf, q, ok);
         cmp("reset read", {31'd0, 1'b1, 16'h0000, RST_L[k]}, {31'd0, ok, q});
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_ranges();
      run_table(0, NR - 1);
      cmp("param output", shadow[16'h1349], params.input_loss_level);
      $display("test ranges done");
   endtask : t_ranges

   task automatic t_comparator();
      run_table(NR, 46);
      cmp("hyst output", 64'd0, params.comparator_hysteresis);
      $display("test comparator done");
   endtask : t_comparator

   task automatic t_refuse();
      logic [31:0] q;
      logic        ok;
      for (int k = 0; k < 6; k++) begin
         refw(ba(RSV_L[k]), 32'h0000_0001, 4'hf);
      end
      refw(ba(16'h1326) | 16'h0001, 32'h0000_0005, 4'hf);
      refw(ba(drive_param_pkg::IDX_STATUS), 32'h0000_0000, 4'hf);
      refw(ba(16'h1326), 32'h0000_0007, 4'h1);
      refw(ba(16'h1326), 32'h0001_0007, 4'hf);
      chk_status(1'b0, 1'b1);
      i_host.xfer(1'b0, ba(16'h1337), 32'h0000_0000, 4'hf, q, ok);
      cmp("reserved read", 64'd0, {31'd0, ok, q});
      wr_chk(16'h1326, 16'h0009, 1'b1);
      chk_status(1'b0, 1'b0);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_class();
      rst_i        <= 1'b1;
      volt_class_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      chk_status(1'b1, 1'b0);
      wr_chk(16'h1335, 16'h1f40, 1'b1);
      wr_chk(16'h1335, 16'h1f41, 1'b0);
      wr_chk(16'h1336, 16'h1f40, 1'b1);
      wr_chk(16'h1336, 16'h1f41, 1'b0);
      $display("test voltage class done");
   endtask : t_class

   // =========================================================
   // verdict
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   always @(posedge hang) begin
      fails++;
      tally_and_finish();
   end

   initial begin
      fails        = 0;
      n_compared   = 0;
      rst_i        = 1'b1;
      volt_class_i = 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_ranges();
      t_comparator();
      t_refuse();
      t_class();
      tally_and_finish();
   end
endmodule : drive_param_bank_tb_top
